/* File: core/mmsd_cfg.svh */
// Contract
// - every address of the one-megabyte space 00000h..FFFFFh is decoded and answered.
// - program ROM tops out at 0FFFFh and grows down by its size, 0F000h..0FFFFh for 4 KB.
// - the fixed vector table sits in ROM at 0FFDCh..0FFFFh, each entry a handler start address.
// - RAM starts at 00400h and grows up by its size, 00400h..004FFh for 256 bytes.
// - RAM accepts reads and writes for data, call frames and interrupt stacking.
// - addresses 00000h..002FFh decode as the special-function register region.
// - mode registers 0 and 1, clock control 1 and write protect reset to 00h, clock control 0 to 58h.
// - the clock source select register at 000Ch resets to 04h.
// - watchdog control resets to 00X11111b and the refresh and start registers are undefined.
// - count source protect resets to 00h, or to 80h when the option select initial bit is 0.
// - oscillator trims at 0021h, 0029h, 002Bh and both reference trims load factory values.
// - two 3-byte match compares at 0010h and 0014h with enable at 0013h all reset to 00h.
// - pin select 4 at 02FBh and timer output control at 02FFh decode and reset to 00h.
// - option select sits at FFFFh in ROM and its value comes from the programmed ROM byte.
// - program writes never change option select; only the external programmer can.
`ifndef MMSD_CFG_SVH
`define MMSD_CFG_SVH
`define MMSD_ADDR_W 20
`define MMSD_SFR_LO 20'h0_0000
`define MMSD_SFR_HI 20'h0_02FF
`define MMSD_RAM_LO 20'h0_0400
`define MMSD_RAM_HI 20'h0_04FF
`define MMSD_ROM_LO 20'h0_F000
`define MMSD_ROM_HI 20'h0_FFFF
`define MMSD_VEC_LO 20'h0_FFDC
`define MMSD_OPT_ADDR 20'h0_FFFF
`define MMSD_NSLOT 27
`define MMSD_NTRIM 5
// register offsets, one per register; each match compare gives only its low byte
`define MMSD_OFF_PMODE0 20'h0_0004
`define MMSD_OFF_PMODE1 20'h0_0005
`define MMSD_OFF_CLKCTL0 20'h0_0006
`define MMSD_OFF_CLKCTL1 20'h0_0007
`define MMSD_OFF_WPROT 20'h0_000A
`define MMSD_OFF_CLKSEL 20'h0_000C
`define MMSD_OFF_WDREF 20'h0_000D
`define MMSD_OFF_WDSTART 20'h0_000E
`define MMSD_OFF_WDCTL 20'h0_000F
`define MMSD_OFF_AMC0 20'h0_0010
`define MMSD_OFF_AMEN 20'h0_0013
`define MMSD_OFF_AMC1 20'h0_0014
`define MMSD_OFF_CSPROT 20'h0_001C
`define MMSD_OFF_FOSC0 20'h0_0020
`define MMSD_OFF_FOSC1 20'h0_0021
`define MMSD_OFF_FOSC2 20'h0_0022
`define MMSD_OFF_PRESC 20'h0_0028
`define MMSD_OFF_FOSC4 20'h0_0029
`define MMSD_OFF_FOSC6 20'h0_002B
`define MMSD_OFF_RTRIMA 20'h0_002E
`define MMSD_OFF_RTRIMB 20'h0_002F
`define MMSD_OFF_PINSEL4 20'h0_02FB
`define MMSD_OFF_TOUTCTL 20'h0_02FF
// reset values
`define MMSD_RST_ZERO 8'h00
`define MMSD_RST_CLKCTL0 8'h58
`define MMSD_RST_CLKSEL 8'h04
`define MMSD_RST_WDCTL 8'h1F
`define MMSD_RST_WDUNDEF 8'h00
`define MMSD_RST_CSPROT_ALT 8'h80
// field positions
`define MMSD_CSP_INIT_BIT 7
`define MMSD_AMEN_BIT0 0
`define MMSD_AMEN_BIT1 1
`endif

/* File: core/mmsd_pkg.sv */
package mmsd_pkg;
   typedef enum logic [1:0] {
      MMSD_REG_NONE,
      MMSD_REG_SFR,
      MMSD_REG_RAM,
      MMSD_REG_ROM
   } mmsd_region_t;
   typedef enum logic {
      MMSD_ST_INIT,
      MMSD_ST_RUN
   } mmsd_state_t;
   typedef logic [7:0] mmsd_byte_t;
endpackage

/* File: core/mmsd_top.sv */
`timescale 1ns/10ps
`include "mmsd_cfg.svh"
module mmsd_top (
   input wire logic CLK_IN,
   input wire logic RESET_IN,
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   input wire logic WB_WE_IN,
   input wire logic [21:0] WB_ADR_IN,
   input wire logic [3:0] WB_SEL_IN,
   input wire logic [31:0] WB_DAT_IN,
   output logic [31:0] WB_DAT_OUT,
   output logic WB_ACK_OUT,
   input wire logic PROG_WE_IN,
   input wire logic [11:0] PROG_ADDR_IN,
   input wire logic [7:0] PROG_DATA_IN,
   input wire logic [39:0] FACTORY_TRIM_IN,
   output logic [1:0] ADDR_MATCH_OUT,
   output logic VECTOR_FETCH_OUT,
   output logic ACCESS_REJECT_OUT,
   output logic READY_OUT
);
   // slot table: offset and reset value of each byte register
   localparam logic [19:0] SLOT_OFF [0:`MMSD_NSLOT-1] = '{
      `MMSD_OFF_PMODE0, `MMSD_OFF_PMODE1, `MMSD_OFF_CLKCTL0, `MMSD_OFF_CLKCTL1,
      `MMSD_OFF_WPROT, `MMSD_OFF_CLKSEL, `MMSD_OFF_WDREF, `MMSD_OFF_WDSTART,
      `MMSD_OFF_WDCTL, `MMSD_OFF_AMC0, `MMSD_OFF_AMC0 + 20'h0_0001,
      `MMSD_OFF_AMC0 + 20'h0_0002, `MMSD_OFF_AMEN, `MMSD_OFF_AMC1,
      `MMSD_OFF_AMC1 + 20'h0_0001, `MMSD_OFF_AMC1 + 20'h0_0002, `MMSD_OFF_CSPROT,
      `MMSD_OFF_FOSC0, `MMSD_OFF_FOSC1, `MMSD_OFF_FOSC2, `MMSD_OFF_PRESC,
      `MMSD_OFF_FOSC4, `MMSD_OFF_FOSC6, `MMSD_OFF_RTRIMA, `MMSD_OFF_RTRIMB,
      `MMSD_OFF_PINSEL4, `MMSD_OFF_TOUTCTL};
   localparam logic [7:0] SLOT_RST [0:`MMSD_NSLOT-1] = '{
      `MMSD_RST_ZERO, `MMSD_RST_ZERO, `MMSD_RST_CLKCTL0, `MMSD_RST_ZERO,
      `MMSD_RST_ZERO, `MMSD_RST_CLKSEL, `MMSD_RST_WDUNDEF, `MMSD_RST_WDUNDEF,
      `MMSD_RST_WDCTL, `MMSD_RST_ZERO, `MMSD_RST_ZERO, `MMSD_RST_ZERO,
      `MMSD_RST_ZERO, `MMSD_RST_ZERO, `MMSD_RST_ZERO, `MMSD_RST_ZERO,
      `MMSD_RST_ZERO, `MMSD_RST_ZERO, `MMSD_RST_ZERO, `MMSD_RST_ZERO,
      `MMSD_RST_ZERO, `MMSD_RST_ZERO, `MMSD_RST_ZERO, `MMSD_RST_ZERO,
      `MMSD_RST_ZERO, `MMSD_RST_ZERO, `MMSD_RST_ZERO};
   // trim slots and which byte of the factory word each one takes
   localparam int TRIM_SLOT [0:`MMSD_NTRIM-1] = '{18, 21, 22, 23, 24};
   localparam int SLOT_CSP = 16;
   localparam int SLOT_AMC0 = 9;
   localparam int SLOT_AMEN = 12;
   localparam int SLOT_AMC1 = 13;
   localparam logic [4:0] SLOT_NONE = 5'h1F;

   mmsd_pkg::mmsd_byte_t sfr_r [0:`MMSD_NSLOT-1];
   mmsd_pkg::mmsd_byte_t ram_r [0:255];
   mmsd_pkg::mmsd_byte_t rom_r [0:4095];
   mmsd_pkg::mmsd_state_t state_r;
   mmsd_pkg::mmsd_region_t region;
   logic [19:0] idx;
   logic [4:0] slot;
   logic req;
   logic do_wr;
   logic ack_r;
   logic [31:0] dat_r;
   logic [1:0] match_r;
   logic vec_r;
   logic rej_r;
   logic ready_r;
   logic [7:0] rd_byte;

   // word index: every byte register occupies one aligned bus word
   assign idx = WB_ADR_IN[21:2];
   // a request is taken once per bus cycle, and only after the init load
   assign req = WB_CYC_IN & WB_STB_IN & ~ack_r & (state_r == mmsd_pkg::MMSD_ST_RUN);

   // region decode over the whole space
   always_comb begin
      if (idx <= `MMSD_SFR_HI) begin
         region = mmsd_pkg::MMSD_REG_SFR;
      end else if (idx >= `MMSD_RAM_LO && idx <= `MMSD_RAM_HI) begin
         region = mmsd_pkg::MMSD_REG_RAM;
      end else if (idx >= `MMSD_ROM_LO && idx <= `MMSD_ROM_HI) begin
         region = mmsd_pkg::MMSD_REG_ROM;
      end else begin
         region = mmsd_pkg::MMSD_REG_NONE;
      end
   end

   // register slot lookup; reserved holes give no slot
   always_comb begin
      slot = SLOT_NONE;
      for (int i = 0; i < `MMSD_NSLOT; i++) begin
         if (region == mmsd_pkg::MMSD_REG_SFR && idx == SLOT_OFF[i]) begin
            slot = 5'(i);
         end
      end
   end

   // writes need the low byte lane; rom and holes never take one
   assign do_wr = req & WB_WE_IN & WB_SEL_IN[0];

   // read data for the current request
   always_comb begin
      case (region)
         mmsd_pkg::MMSD_REG_SFR: begin
            rd_byte = (slot == SLOT_NONE) ? 8'h00 : sfr_r[slot];
         end
         mmsd_pkg::MMSD_REG_RAM: begin
            rd_byte = ram_r[idx[7:0]];
         end
         mmsd_pkg::MMSD_REG_ROM: begin
            rd_byte = rom_r[idx[11:0]];
         end
         default: begin
            rd_byte = 8'h00;
         end
      endcase
   end

   // init sequencer: one cycle after reset release loads the factory values
   always_ff @(posedge CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         state_r <= mmsd_pkg::MMSD_ST_INIT;
      end else begin
         case (state_r)
            mmsd_pkg::MMSD_ST_INIT: begin
               state_r <= mmsd_pkg::MMSD_ST_RUN;
            end
            mmsd_pkg::MMSD_ST_RUN: begin
               state_r <= mmsd_pkg::MMSD_ST_RUN;
            end
            default: begin
               state_r <= mmsd_pkg::MMSD_ST_INIT;
            end
         endcase
      end
   end

   // one flop per register byte; reset takes constants, straps load afterwards
   generate
      for (genvar g = 0; g < `MMSD_NSLOT; g++) begin : g_sfr
         localparam bit IS_CSP = (g == SLOT_CSP);
         localparam int TRIM_IDX = (g == TRIM_SLOT[0]) ? 0 : (g == TRIM_SLOT[1]) ? 1 :
            (g == TRIM_SLOT[2]) ? 2 : (g == TRIM_SLOT[3]) ? 3 : (g == TRIM_SLOT[4]) ? 4 : -1;
         // clamped lane keeps the part-select in range for slots that take no trim
         localparam int TRIM_LANE = (TRIM_IDX < 0) ? 0 : TRIM_IDX;
         always_ff @(posedge CLK_IN or posedge RESET_IN) begin
            if (RESET_IN) begin
               sfr_r[g] <= SLOT_RST[g];
            end else if (state_r == mmsd_pkg::MMSD_ST_INIT) begin
               if (TRIM_IDX >= 0) begin
                  sfr_r[g] <= FACTORY_TRIM_IN[8*TRIM_LANE +: 8];
               end else if (IS_CSP && !rom_r[4095][`MMSD_CSP_INIT_BIT]) begin
                  sfr_r[g] <= `MMSD_RST_CSPROT_ALT;
               end
            end else if (do_wr && slot == 5'(g)) begin
               sfr_r[g] <= WB_DAT_IN[7:0];
            end
         end
      end
   endgenerate

   // ram storage, no reset: contents are undefined at power up
   always_ff @(posedge CLK_IN) begin
      if (do_wr && region == mmsd_pkg::MMSD_REG_RAM) begin
         ram_r[idx[7:0]] <= WB_DAT_IN[7:0];
      end
   end

   // rom is written only from the programmer port, never from the bus
   always_ff @(posedge CLK_IN) begin
      if (PROG_WE_IN) begin
         rom_r[PROG_ADDR_IN] <= PROG_DATA_IN;
      end
   end

   // bus answer: ack one cycle after the request, dropped the cycle after
   always_ff @(posedge CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
      end else begin
         ack_r <= req;
         if (req) begin
            dat_r <= {24'h00_0000, WB_WE_IN ? 8'h00 : rd_byte};
         end
      end
   end

   // address match: enabled compares flag a hit on the requested address
   always_ff @(posedge CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         match_r <= 2'b00;
      end else begin
         match_r[0] <= req & sfr_r[SLOT_AMEN][`MMSD_AMEN_BIT0] &
            (idx == {sfr_r[SLOT_AMC0+2][3:0], sfr_r[SLOT_AMC0+1], sfr_r[SLOT_AMC0]});
         match_r[1] <= req & sfr_r[SLOT_AMEN][`MMSD_AMEN_BIT1] &
            (idx == {sfr_r[SLOT_AMC1+2][3:0], sfr_r[SLOT_AMC1+1], sfr_r[SLOT_AMC1]});
      end
   end

   // status pulses: vector table reads and refused accesses
   always_ff @(posedge CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         vec_r <= 1'b0;
         rej_r <= 1'b0;
      end else begin
         vec_r <= req & ~WB_WE_IN & (idx >= `MMSD_VEC_LO) & (idx <= `MMSD_ROM_HI);
         // holes, unmapped space and bus writes to rom all land here
         rej_r <= req & ((region == mmsd_pkg::MMSD_REG_NONE) |
            (region == mmsd_pkg::MMSD_REG_SFR && slot == SLOT_NONE) |
            (WB_WE_IN & region == mmsd_pkg::MMSD_REG_ROM));
      end
   end

   // ready flag tells the core the init load is done
   always_ff @(posedge CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         ready_r <= 1'b0;
      end else begin
         ready_r <= (state_r == mmsd_pkg::MMSD_ST_RUN);
      end
   end

   assign WB_ACK_OUT = ack_r;
   assign WB_DAT_OUT = dat_r;
   assign ADDR_MATCH_OUT = match_r;
   assign VECTOR_FETCH_OUT = vec_r;
   assign ACCESS_REJECT_OUT = rej_r;
   assign READY_OUT = ready_r;
endmodule

/* File: verification/mmsd_chk.sv */
`timescale 1ns/10ps
module mmsd_chk (
   input wire logic CLK_IN,
   input wire logic RESET_IN,
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   input wire logic WB_WE_IN,
   input wire logic [21:0] WB_ADR_IN,
   input wire logic [31:0] WB_DAT_OUT,
   input wire logic WB_ACK_OUT,
   input wire logic [1:0] ADDR_MATCH_OUT,
   input wire logic VECTOR_FETCH_OUT,
   input wire logic ACCESS_REJECT_OUT,
   input wire logic READY_OUT
);
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (RESET_IN);
   // word index seen by the decoder
   logic [19:0] a;
   assign a = WB_ADR_IN[21:2];
   // a request taken in run state
   sequence take_s;
      WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT && READY_OUT;
   endsequence
   ack_follows_a: assert property (take_s |=> WB_ACK_OUT) else $error("no ack");
   ack_pulse_a: assert property (WB_ACK_OUT |=> !WB_ACK_OUT) else $error("long ack");
   ack_cause_a: assert property (WB_ACK_OUT |-> $past(WB_CYC_IN && WB_STB_IN)) else $error("stray ack");
   dat_upper_a: assert property (WB_ACK_OUT |-> WB_DAT_OUT[31:8] == 24'h00_0000) else $error("upper data");
   vec_fetch_a: assert property (take_s ##0 (!WB_WE_IN && a >= 20'h0_FFDC && a <= 20'h0_FFFF)
      |=> VECTOR_FETCH_OUT) else $error("no vector flag");
   vec_only_a: assert property (VECTOR_FETCH_OUT |-> WB_ACK_OUT && $past(a) >= 20'h0_FFDC)
      else $error("stray vector flag");
   ram_open_a: assert property (take_s ##0 (a >= 20'h0_0400 && a <= 20'h0_04FF) |=> !ACCESS_REJECT_OUT)
      else $error("ram refused");
   sfr_edge_a: assert property (take_s ##0 (a >= 20'h0_0300 && a < 20'h0_0400) |=> ACCESS_REJECT_OUT)
      else $error("gap accepted");
   rom_write_a: assert property (take_s ##0 (WB_WE_IN && a >= 20'h0_F000 && a <= 20'h0_FFFF)
      |=> ACCESS_REJECT_OUT) else $error("rom write taken");
   unmap_rej_a: assert property (take_s ##0 (a >= 20'h0_0500 && a < 20'h0_F000 || a > 20'h0_FFFF)
      |=> ACCESS_REJECT_OUT) else $error("unmapped taken");
   match_ack_a: assert property (ADDR_MATCH_OUT != 2'b00 |-> WB_ACK_OUT) else $error("stray match");
endmodule
bind mmsd_top mmsd_chk chk (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN),
   .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN), .WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT),
   .ADDR_MATCH_OUT(ADDR_MATCH_OUT), .VECTOR_FETCH_OUT(VECTOR_FETCH_OUT),
   .ACCESS_REJECT_OUT(ACCESS_REJECT_OUT), .READY_OUT(READY_OUT));

/* File: verification/mmsd_cpu.sv */
`timescale 1ns/10ps
// bus master in place of the processor core
module mmsd_cpu (
   input wire logic clk_in,
   input wire logic ack_in,
   input wire logic [31:0] dat_in,
   input wire logic [3:0] st_in,
   output logic cyc_out = 1'b0,
   output logic we_out = 1'b0,
   output logic [21:0] adr_out = 22'h00_0000,
   output logic [3:0] sel_out = 4'h0,
   output logic [31:0] dat_out = 32'h0000_0000
);
   // one classic cycle; on release the address and write data lines are inverted so stale values cannot pass
   task xfer(input logic w, input logic [19:0] a, input logic [7:0] d, input logic s,
      output logic [7:0] q, output logic [3:0] st, output bit to);
      int n;
      begin
         cyc_out <= 1'b1;
         we_out <= w;
         adr_out <= {a, 2'b00};
         sel_out <= {3'b000, s};
         dat_out <= {24'h00_0000, d};
         to = 1'b1;
         for (n = 0; n < 40 && to; n++) begin
            @(posedge clk_in);
            to = (ack_in !== 1'b1);
         end
         q = dat_in[7:0];
         st = st_in;
         cyc_out <= 1'b0;
         adr_out <= ~adr_out;
         dat_out <= ~dat_out;
         @(posedge clk_in);
      end
   endtask
endmodule

/* File: verification/memory_map_sfr_decode_test.sv */
`timescale 1ns/10ps
module memory_map_sfr_decode_test;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic prog_we = 1'b0;
   logic [11:0] prog_adr = 12'h000;
   logic [7:0] prog_dat = 8'h00;
   logic [39:0] trim = 40'h00_0000_0000;
   logic cyc, we, ack, vf, rej, rdy;
   logic [21:0] adr;
   logic [3:0] sel, last_st;
   logic [31:0] wdat, rdat;
   logic [1:0] am;
   int bad_count = 0;
   int checks_done = 0;
   logic [31:0] seed = 32'h0001_5188;
   logic [7:0] m [int];
   int ra [27] = '{4, 5, 6, 7, 'hA, 'hC, 'hD, 'hE, 'hF, 'h10, 'h11, 'h12, 'h13, 'h14, 'h15, 'h16, 'h1C,
      'h20, 'h21, 'h22, 'h28, 'h29, 'h2B, 'h2E, 'h2F, 'h2FB, 'h2FF};
   int xa [9] = '{'h400, 'h4FF, 'h3FF, 'h500, 'h8, 'h2FC, 'hF000, 'hFFFF, 'hFFFFF};
   int mt [7] = '{'h10, 'h11, 'h12, 'h14, 'h15, 'h16, 'h13};
   logic [7:0] mv [7] = '{8'h00, 8'h04, 8'h00, 8'hFF, 8'h04, 8'h00, 8'h03};
   mmsd_top dut (.CLK_IN(clk), .RESET_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(cyc), .WB_WE_IN(we),
      .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
      .PROG_WE_IN(prog_we), .PROG_ADDR_IN(prog_adr), .PROG_DATA_IN(prog_dat), .FACTORY_TRIM_IN(trim),
      .ADDR_MATCH_OUT(am), .VECTOR_FETCH_OUT(vf), .ACCESS_REJECT_OUT(rej), .READY_OUT(rdy));
   mmsd_cpu cpu (.clk_in(clk), .ack_in(ack), .dat_in(rdat), .st_in({rej, vf, am}), .cyc_out(cyc),
      .we_out(we), .adr_out(adr), .sel_out(sel), .dat_out(wdat));
   // free-running 100 MHz clock
   initial begin
      forever #5 clk = ~clk;
   end
   function logic [7:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[7:0];
   endfunction
   task tally_and_finish;
      if (bad_count == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk8(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH t=%0t data got %h exp %h", $time, g, e);
      end
   endtask
   task chkst(input logic [1:0] g, input logic [1:0] e);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH t=%0t flags got %h exp %h", $time, g, e);
      end
   endtask
   // one bus access checked against the byte model
   task op(input logic w, input int a, input logic [7:0] d, input logic s);
      logic [7:0] q;
      bit to, map;
      begin
         map = (a < 'h300 && m.exists(a)) || (a >= 'h400 && a <= 'h4FF);
         cpu.xfer(w, a[19:0], d, s, q, last_st, to);
         if (to) begin
            bad_count++;
            tally_and_finish();
         end
         chkst(last_st[3:2], {!(map || !w && a >= 'hF000 && a <= 'hFFFF), !w && a >= 'hFFDC && a <= 'hFFFF});
         if (w && s && map) m[a] = d;
         if (!w) chk8(q, m.exists(a) ? m[a] : 8'h00);
      end
   endtask
   // reset with fresh trims; rom and ram survive, so only sfr slots are reloaded
   task mreset(input logic [7:0] csp, input int n);
      int i;
      begin
         trim <= {rnd(), rnd(), rnd(), rnd(), rnd()};
         rst <= 1'b1;
         repeat (n) @(posedge clk);
         rst <= 1'b0;
         foreach (ra[k]) m[ra[k]] = 8'h00;
         m['h6] = 8'h58;
         m['hC] = 8'h04;
         m['hF] = 8'h1F;
         m['h1C] = csp;
         {m['h2F], m['h2E], m['h2B], m['h29], m['h21]} = trim;
         for (i = 0; i < 20 && rdy !== 1'b1; i++) @(posedge clk);
         if (rdy !== 1'b1) begin
            bad_count++;
            tally_and_finish();
         end
         @(posedge clk);
      end
   endtask
   task prog(input logic [11:0] o, input logic [7:0] d);
      prog_we <= 1'b1;
      prog_adr <= o;
      prog_dat <= d;
      @(posedge clk);
      prog_we <= 1'b0;
      m['hF000 + o] = d;
      @(posedge clk);
   endtask
   initial begin
      @(posedge clk);
      mreset(8'h00, 20);
      prog(12'hFFF, 8'h00);
      prog(12'h000, rnd());
      prog(12'hFDC, rnd());
      prog(12'h7EE, rnd());
      mreset(8'h80, 3);
      foreach (ra[i]) op(1'b0, ra[i], 8'h00, 1'b1);
      foreach (xa[i]) op(1'b0, 'hF000 + (i % 3) * 'h7EE, 8'h00, 1'b1);
      foreach (ra[i]) op(1'b1, ra[i], rnd(), 1'b1);
      foreach (ra[i]) op(1'b0, ra[i], 8'h00, 1'b1);
      foreach (xa[i]) begin
         op(1'b1, xa[i], rnd(), 1'b1);
         op(1'b0, xa[i], 8'h00, 1'b1);
      end
      op(1'b1, 'h4, 8'hA5, 1'b0);
      op(1'b0, 'h4, 8'h00, 1'b1);
      foreach (mt[i]) op(1'b1, mt[i], mv[i], 1'b1);
      op(1'b0, 'h400, 8'h00, 1'b1);
      chkst(last_st[1:0], 2'b01);
      op(1'b0, 'h4FF, 8'h00, 1'b1);
      chkst(last_st[1:0], 2'b10);
      prog(12'hFFF, 8'h80);
      mreset(8'h00, 3);
      op(1'b0, 'h1C, 8'h00, 1'b1);
      tally_and_finish();
   end
endmodule
